/* afb_params.svh */
// afb_params.svh: timing counts and field values for the parallel port
// assumes: included by bare name only in the port module's file, not in the fifo, sync or package files
`ifndef AFB_PARAMS_SVH
`define AFB_PARAMS_SVH

`define AFB_CLK_PERIOD_NS   20
`define AFB_STB_PULSE_NS    100
`define AFB_STB_PULSE_CYC   ((`AFB_STB_PULSE_NS + `AFB_CLK_PERIOD_NS - 1) \
                             / `AFB_CLK_PERIOD_NS)
`define AFB_SYNC_BB_DIV     8
`define AFB_DATA_W          8
`define AFB_FIFO_DEPTH      32
`define AFB_BYTE_ZERO       8'h00
`define AFB_MODE_W          2
`define AFB_CNT_W           8

`endif

/* afb_pkg.sv */
// afb_pkg.sv: types shared by the parallel port modules
// assumes: nothing, not even the params header
`default_nettype none
package afb_pkg;
   typedef enum logic [1:0]
   {
      AFB_MODE_OFF     = 2'b00,
      AFB_MODE_FIFO    = 2'b01,
      AFB_MODE_BB_ASYN = 2'b10,
      AFB_MODE_BB_SYN  = 2'b11
   } afb_mode_e;

   typedef enum logic [1:0]
   {
      AFB_RD_IDLE = 2'b00,
      AFB_RD_DRV  = 2'b01,
      AFB_RD_ADV  = 2'b10
   } afb_rd_e;
endpackage
`default_nettype wire

/* afb_fifo.sv */
// afb_fifo.sv: synchronous fifo with registered read data
// assumes: one clock, valid/ready on both sides, show-ahead output
`timescale 1ns/1ps
`default_nettype none
module afb_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_r] <= in_data;
   end

   // head word held in a register so the pad driver never sees ram glitches
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         out_data <= '0;
      else if (count_r == '0 || (pop && count_r == (AW+1)'(1)))
         out_data <= in_data;
      else if (pop)
         out_data <= mem[AW'(rd_ptr_r + 1'b1)];
      else
         out_data <= mem[rd_ptr_r];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
         if (pop)
            rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
         count_r <= (AW+1)'(count_r + push - pop);
      end
   end
endmodule
`default_nettype wire

/* afb_sync.sv */
// afb_sync.sv: two-flop synchroniser with edge detection on the clean side
// assumes: input comes from a pin outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module afb_sync
#(
   parameter logic RST_VAL = 1'b1
)
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic async_in,
   output logic      sync_out,
   output logic      rise,
   output logic      fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
         last_r <= RST_VAL;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign sync_out = sync_r;
   assign rise     = sync_r && !last_r;
   assign fall     = !sync_r && last_r;
endmodule
`default_nettype wire

/* afb_port.sv */
// afb_port.sv: one channel of the byte-wide parallel port, device side
// assumes: usb side delivers/takes bytes by valid/ready on clk; strobes
// and send_now_wake_n are asynchronous pins; mode comes from config
//
// Summary of operation
// - fifo mode chosen per channel only by the stored configuration mode
// - fifo transfers are referenced to falling strobe edges
// - outside bit-bang, data bus stays input except while read_strobe_n is low
// - read_avail_n low when a byte waits; host reads only then
// - read_avail_n goes high after each read; low again only if more
// - flags undriven during reset, pulled high externally
// - write_room_n low when a byte fits; host writes only then
// - falling read_strobe_n puts the head byte on the bus
// - rising read_strobe_n advances to the next byte
// - falling write_strobe_n captures the bus into the transmit buffer
// - suspended with wakeup enabled: send_now_wake_n low requests resume
// - awake: send_now_wake_n low requests a flush of pending transmit data
// - bit-bang turns the eight lines into a bus, sync and async
// - bit-bang pulses out_update_strobe_n low after new output data
// - bit-bang raises in_sample_strobe after a sample goes to the host
`timescale 1ns/1ps
`default_nettype none
`include "afb_params.svh"
module afb_port
#(
   parameter int DATA_W = `AFB_DATA_W,
   parameter int DEPTH  = `AFB_FIFO_DEPTH
)
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic [1:0]        cfg_mode,
   input  wire logic              cfg_wake_en,
   input  wire logic              power_enable_n,
   input  wire logic [DATA_W-1:0] port_a_data_in,
   output logic      [DATA_W-1:0] port_a_data_out,
   output logic      [DATA_W-1:0] port_a_data_oe,
   input  wire logic              read_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic              send_now_wake_n,
   output logic                   read_avail_n,
   output logic                   read_avail_oe,
   output logic                   write_room_n,
   output logic                   write_room_oe,
   output logic                   out_update_strobe_n,
   output logic                   in_sample_strobe,
   input  wire logic              rx_valid,
   output logic                   rx_ready,
   input  wire logic [DATA_W-1:0] rx_data,
   output logic                   tx_valid,
   input  wire logic              tx_ready,
   output logic      [DATA_W-1:0] tx_data,
   input  wire logic [DATA_W-1:0] bb_dir,
   output logic                   resume_req,
   output logic                   flush_req
);
   // -------------------------------------------------------------
   // mode and synchronised inputs
   // -------------------------------------------------------------
   localparam int PULSE_CYC = `AFB_STB_PULSE_CYC;

   afb_pkg::afb_mode_e mode;
   afb_pkg::afb_rd_e   rd_state_r;
   logic               fifo_mode;
   logic               bb_mode;
   logic               rd_s;
   logic               rd_rise;
   logic               rd_fall;
   logic               wr_fall;
   logic               wk_fall;
   logic [DATA_W-1:0]  din_meta_r;
   logic [DATA_W-1:0]  din_sync_r;
   logic               avail_hide_r;
   logic [DATA_W-1:0]  rx_head;
   logic               rx_head_valid;
   logic               rx_pop;
   logic               rxf_in_ready;
   logic               txf_out_valid;
   logic [DATA_W-1:0]  txf_out_data;
   logic               tx_push;
   logic               txf_in_ready;
   logic [DATA_W-1:0]  bb_out_r;
   logic [`AFB_CNT_W-1:0] upd_cnt_r;
   logic [`AFB_CNT_W-1:0] smp_cnt_r;
   logic [`AFB_CNT_W-1:0] div_cnt_r;
   logic               tick;
   logic               bb_sample;
   logic               out_pop;

   // config is the only mode source; no pin can override it
   assign mode      = afb_pkg::afb_mode_e'(cfg_mode);
   assign fifo_mode = (mode == afb_pkg::AFB_MODE_FIFO);
   assign bb_mode   = (mode == afb_pkg::AFB_MODE_BB_ASYN) ||
                      (mode == afb_pkg::AFB_MODE_BB_SYN);

   afb_sync #(.RST_VAL(1'b1)) u_rd_sync
   (
      .clk      (clk),
      .rstn     (rstn),
      .async_in (read_strobe_n),
      .sync_out (rd_s),
      .rise     (rd_rise),
      .fall     (rd_fall)
   );

   afb_sync #(.RST_VAL(1'b1)) u_wr_sync
   (
      .clk      (clk),
      .rstn     (rstn),
      .async_in (write_strobe_n),
      .sync_out (),
      .rise     (),
      .fall     (wr_fall)
   );

   afb_sync #(.RST_VAL(1'b1)) u_wk_sync
   (
      .clk      (clk),
      .rstn     (rstn),
      .async_in (send_now_wake_n),
      .sync_out (),
      .rise     (),
      .fall     (wk_fall)
   );

   // data pins pass two flops as a group; host holds them stable
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         din_meta_r <= `AFB_BYTE_ZERO;
         din_sync_r <= `AFB_BYTE_ZERO;
      end
      else
      begin
         din_meta_r <= port_a_data_in;
         din_sync_r <= din_meta_r;
      end
   end

   // -------------------------------------------------------------
   // buffers toward and from usb
   // -------------------------------------------------------------
   afb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo
   (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (rx_valid),
      .in_ready  (rxf_in_ready),
      .in_data   (rx_data),
      .out_valid (rx_head_valid),
      .out_ready (rx_pop),
      .out_data  (rx_head)
   );

   afb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo
   (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (tx_push),
      .in_ready  (txf_in_ready),
      .in_data   (din_sync_r),
      .out_valid (txf_out_valid),
      .out_ready (tx_ready),
      .out_data  (txf_out_data)
   );

   assign rx_ready = rxf_in_ready;
   assign tx_valid = txf_out_valid;
   assign tx_data  = txf_out_data;

   // -------------------------------------------------------------
   // fifo mode read side
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rd_state_r <= afb_pkg::AFB_RD_IDLE;
      else
      begin
         case (rd_state_r)
            afb_pkg::AFB_RD_IDLE:
               if (fifo_mode && rd_fall)
                  rd_state_r <= afb_pkg::AFB_RD_DRV;
            afb_pkg::AFB_RD_DRV:
               if (rd_rise)
                  rd_state_r <= afb_pkg::AFB_RD_ADV;
            afb_pkg::AFB_RD_ADV:
               rd_state_r <= afb_pkg::AFB_RD_IDLE;
            default:
               rd_state_r <= afb_pkg::AFB_RD_IDLE;
         endcase
      end
   end

   // fifo read pops on the strobe's rising edge, only if a byte was there; bit-bang pops on out_pop
   assign rx_pop = (bb_mode && out_pop) ||
                   (rd_state_r == afb_pkg::AFB_RD_DRV && rd_rise &&
                    rx_head_valid);

   // flag is hidden from the read's end until the next head settles
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         avail_hide_r <= 1'b0;
      else if (rd_state_r == afb_pkg::AFB_RD_DRV && rd_rise)
         avail_hide_r <= 1'b1;
      else if (rd_state_r == afb_pkg::AFB_RD_IDLE)
         avail_hide_r <= 1'b0;
   end

   // flags: pad not driven while reset is held
   assign read_avail_oe = rstn;
   assign write_room_oe = rstn;
   assign read_avail_n  = !(fifo_mode && rx_head_valid && !avail_hide_r &&
                            rd_state_r != afb_pkg::AFB_RD_ADV);
   assign write_room_n  = !(fifo_mode && txf_in_ready);

   // -------------------------------------------------------------
   // write side, fifo capture and bit-bang sampling share the buffer
   // -------------------------------------------------------------
   // host only strobes while room is shown, so a full buffer drops it
   assign tx_push = (fifo_mode && wr_fall) || (bb_mode && bb_sample);

   // -------------------------------------------------------------
   // bit-bang engine
   // -------------------------------------------------------------
   // sync variant samples with each output update, async on a divided tick; both only when room exists
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         div_cnt_r <= '0;
      else if (div_cnt_r == `AFB_CNT_W'(`AFB_SYNC_BB_DIV - 1))
         div_cnt_r <= '0;
      else
         div_cnt_r <= `AFB_CNT_W'(div_cnt_r + 1'b1);
   end

   assign tick      = (div_cnt_r == '0);
   assign out_pop   = rx_head_valid && tick && upd_cnt_r == '0;
   assign bb_sample = txf_in_ready && smp_cnt_r == '0 &&
                      ((mode == afb_pkg::AFB_MODE_BB_SYN) ? out_pop : tick);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         bb_out_r <= `AFB_BYTE_ZERO;
      else if (bb_mode && out_pop)
         bb_out_r <= rx_head;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         upd_cnt_r <= '0;
      else if (bb_mode && out_pop)
         upd_cnt_r <= `AFB_CNT_W'(PULSE_CYC);
      else if (upd_cnt_r != '0)
         upd_cnt_r <= `AFB_CNT_W'(upd_cnt_r - 1'b1);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         smp_cnt_r <= '0;
      else if (bb_mode && bb_sample)
         smp_cnt_r <= `AFB_CNT_W'(PULSE_CYC);
      else if (smp_cnt_r != '0)
         smp_cnt_r <= `AFB_CNT_W'(smp_cnt_r - 1'b1);
   end

   // strobes held low during the pulse; rising edge marks completion
   assign out_update_strobe_n = !(bb_mode && upd_cnt_r != '0);
   assign in_sample_strobe    = !(bb_mode && smp_cnt_r != '0);

   // -------------------------------------------------------------
   // data pad drive
   // -------------------------------------------------------------
   always_comb
   begin
      port_a_data_out = `AFB_BYTE_ZERO;
      port_a_data_oe  = '0;
      if (fifo_mode && !rd_s && rd_state_r == afb_pkg::AFB_RD_DRV)
      begin
         port_a_data_out = rx_head;
         port_a_data_oe  = '1;
      end
      else if (bb_mode)
      begin
         port_a_data_out = bb_out_r;
         port_a_data_oe  = bb_dir;
      end
   end

   // -------------------------------------------------------------
   // send-immediate and wakeup
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         resume_req <= 1'b0;
         flush_req  <= 1'b0;
      end
      else
      begin
         resume_req <= wk_fall && power_enable_n && cfg_wake_en;
         flush_req  <= wk_fall && !power_enable_n;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   sequence rd_low_seq;
      fifo_mode && rd_fall;
   endsequence

   bus_input_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      (port_a_data_oe != '0 && fifo_mode) |-> !rd_s)
      else $error("data bus driven with read strobe high");
   avail_after_rd_a: assert property (@(posedge clk) disable iff (!rstn)
      (rd_state_r == afb_pkg::AFB_RD_DRV && rd_rise) |=> read_avail_n)
      else $error("avail flag not raised after read");
   head_on_bus_a: assert property (@(posedge clk) disable iff (!rstn)
      rd_low_seq ##1 !rd_s |-> port_a_data_out == rx_head)
      else $error("head byte not on bus");
   avail_empty_a: assert property (@(posedge clk) disable iff (!rstn)
      !rx_head_valid |-> read_avail_n)
      else $error("avail shown with empty buffer");
   wr_capture_a: assert property (@(posedge clk) disable iff (!rstn)
      (fifo_mode && wr_fall && txf_in_ready) |=> tx_valid)
      else $error("write strobe byte not captured");
   room_full_a: assert property (@(posedge clk) disable iff (!rstn)
      !txf_in_ready |-> write_room_n)
      else $error("room shown with full buffer");
   wake_resume_a: assert property (@(posedge clk) disable iff (!rstn)
      (wk_fall && power_enable_n && cfg_wake_en) |=> resume_req)
      else $error("resume not requested");
   flush_req_a: assert property (@(posedge clk) disable iff (!rstn)
      (wk_fall && !power_enable_n) |=> flush_req && !resume_req)
      else $error("flush not requested");
   upd_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      (bb_mode && out_pop) |=> !out_update_strobe_n [*5] ##1 out_update_strobe_n)
      else $error("update strobe length wrong");
   smp_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      (bb_mode && bb_sample) |=> !in_sample_strobe [*5] ##1 in_sample_strobe)
      else $error("sample strobe length wrong");
endmodule
`default_nettype wire

/* afb_host_model.sv */
// afb_host_model.sv: external controller facing the fifo/bit-bang port
// assumes: bench resolves the pads from both enables; tasks start at posedge
`timescale 1ns/1ps
`default_nettype none
module afb_host_model
(
   input  wire logic       clk,
   input  wire logic [7:0] bus,
   input  wire logic       read_avail_n,
   input  wire logic       write_room_n,
   output logic            read_strobe_n,
   output logic            write_strobe_n,
   output logic            send_now_wake_n,
   output logic      [7:0] drv_data,
   output logic            drv_en
);
   // --------------------------------------------------------------
   // strobe sequences
   // --------------------------------------------------------------
   initial
   begin
      read_strobe_n   = 1'b1;
      write_strobe_n  = 1'b1;
      send_now_wake_n = 1'b1;
      drv_data        = 8'h00;
      drv_en          = 1'b0;
   end

   // a flag that never comes is taken as a refusal
   task automatic wait_flag(input logic use_rx, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 200 && !ok; i++)
      begin
         @(negedge clk);
         ok = use_rx ? (read_avail_n === 1'b0) : (write_room_n === 1'b0);
      end
      @(posedge clk);
   endtask

   task automatic rd(output logic [7:0] d, output logic fl, output logic ok);
      d  = 8'h00;
      fl = 1'b0;
      wait_flag(1'b1, ok);
      if (ok)
      begin
         read_strobe_n <= 1'b0;
         repeat (7) @(posedge clk);
         @(negedge clk);
         d = bus;
         @(posedge clk);
         read_strobe_n <= 1'b1;
         repeat (4) @(posedge clk);
         @(negedge clk);
         fl = read_avail_n;
         @(posedge clk);
      end
   endtask

   // data held well around the fall: the pads pass a synchroniser
   task automatic wr(input logic [7:0] d, output logic ok);
      wait_flag(1'b0, ok);
      if (ok)
      begin
         drv_data <= d;
         drv_en   <= 1'b1;
         repeat (4) @(posedge clk);
         write_strobe_n <= 1'b0;
         repeat (6) @(posedge clk);
         write_strobe_n <= 1'b1;
         repeat (4) @(posedge clk);
         drv_en <= 1'b0;
      end
   endtask

   task automatic drive(input logic [7:0] d);
      drv_data <= d;
      drv_en   <= 1'b1;
   endtask

   task automatic wake();
      send_now_wake_n <= 1'b0;
      repeat (4) @(posedge clk);
      send_now_wake_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* afb_tb.sv */
// afb_tb.sv: self-checking bench for one channel of the parallel port
// assumes: afb_pkg and the port modules compiled before this file
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk, rstn, cfg_wake_en, power_enable_n;
   logic [1:0] cfg_mode;
   logic       rx_valid, tx_ready;
   logic [7:0] rx_data, bb_dir, pad, drv_data;
   logic [7:0] port_a_data_out, port_a_data_oe, tx_data;
   logic       read_strobe_n, write_strobe_n, send_now_wake_n, drv_en;
   logic       read_avail_n, read_avail_oe, write_room_n, write_room_oe;
   logic       out_update_strobe_n, in_sample_strobe, rx_ready, tx_valid;
   logic       resume_req, flush_req;
   logic       avail_pin, room_pin;

   // flag pads float in reset; the weak pull-up then holds them high
   assign avail_pin = read_avail_oe ? read_avail_n : 1'b1;
   assign room_pin  = write_room_oe ? write_room_n : 1'b1;
   int         n_mismatch;
   int         samples_checked;

   // undriven pad bits show the host's value while it drives, else its inverse
   assign pad = (port_a_data_oe & port_a_data_out)
              | (~port_a_data_oe & (drv_en ? drv_data : ~drv_data));

   afb_port #(.DATA_W(8), .DEPTH(32)) dut_u
   (
      .clk(clk), .rstn(rstn), .cfg_mode(cfg_mode),
      .cfg_wake_en(cfg_wake_en), .power_enable_n(power_enable_n),
      .port_a_data_in(pad), .port_a_data_out(port_a_data_out),
      .port_a_data_oe(port_a_data_oe), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .send_now_wake_n(send_now_wake_n),
      .read_avail_n(read_avail_n), .read_avail_oe(read_avail_oe),
      .write_room_n(write_room_n), .write_room_oe(write_room_oe),
      .out_update_strobe_n(out_update_strobe_n),
      .in_sample_strobe(in_sample_strobe), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .bb_dir(bb_dir),
      .resume_req(resume_req), .flush_req(flush_req)
   );

   afb_host_model ext_u
   (
      .clk(clk), .bus(pad), .read_avail_n(avail_pin),
      .write_room_n(room_pin), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .send_now_wake_n(send_now_wake_n),
      .drv_data(drv_data), .drv_en(drv_en)
   );

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // --------------------------------------------------------------
   // checking and closing
   // --------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected=%h seen=%h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic to_fail(input string what);
      n_mismatch++;
      $display("ERROR %s expected=event seen=timeout", what);
      end_of_test();
   endtask

   task automatic push(input logic [7:0] d, output logic ok);
      rx_data  <= d;
      rx_valid <= 1'b1;
      @(negedge clk);
      ok = (rx_ready === 1'b1);
      @(posedge clk);
   endtask

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial
   begin
      logic [7:0] d;
      logic       f, ok;
      int         i, k, n, c;
      n_mismatch = 0;
      samples_checked = 0;
      rstn = 1'b0;
      cfg_mode = 2'h0;
      cfg_wake_en = 1'b0;
      power_enable_n = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
      bb_dir = 8'h00;
      repeat (11) @(posedge clk);
      @(negedge clk);
      chk("read_avail_oe in reset", 8'h00, 8'(read_avail_oe));
      chk("write_room_oe in reset", 8'h00, 8'(write_room_oe));
      chk("data oe in reset", 8'h00, port_a_data_oe);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      cfg_mode <= afb_pkg::AFB_MODE_FIFO;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("read_avail_n empty", 8'h01, 8'(read_avail_n));
      chk("write_room_n empty", 8'h00, 8'(write_room_n));
      @(posedge clk);
      n = 0;
      for (i = 0; i < 40; i++)
      begin
         push(8'(i * 7 + 3), ok);
         if (!ok)
            break;
         n++;
      end
      rx_valid <= 1'b0;
      chk("rx bytes accepted", 8'h20, 8'(n));
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("read_avail_n filled", 8'h00, 8'(read_avail_n));
      @(posedge clk);
      for (i = 0; i < 32; i++)
      begin
         ext_u.rd(d, f, ok);
         if (!ok)
            to_fail("read_avail_n");
         chk("rx byte", 8'(i * 7 + 3), d);
         chk("read_avail_n after read", 8'h01, 8'(f));
         @(negedge clk);
         chk("data oe idle", 8'h00, port_a_data_oe);
         @(posedge clk);
      end
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("read_avail_n drained", 8'h01, 8'(read_avail_n));
      @(posedge clk);
      n = 0;
      for (i = 0; i < 40; i++)
      begin
         ext_u.wr(8'(i ^ 8'hC5), ok);
         if (!ok)
            break;
         n++;
      end
      chk("writes accepted", 8'h20, 8'(n));
      @(negedge clk);
      chk("write_room_n full", 8'h01, 8'(write_room_n));
      @(posedge clk);
      tx_ready <= 1'b1;
      k = 0;
      for (i = 0; i < 200; i++)
      begin
         @(negedge clk);
         if (tx_valid === 1'b1)
         begin
            chk("tx byte", 8'(k ^ 8'hC5), tx_data);
            k++;
         end
      end
      chk("tx bytes", 8'h20, 8'(k));
      chk("write_room_n drained", 8'h00, 8'(write_room_n));
      for (c = 0; c < 4; c++)
      begin
         @(posedge clk);
         power_enable_n <= c[1];
         cfg_wake_en <= c[0];
         repeat (4) @(posedge clk);
         n = 0;
         k = 0;
         fork
            ext_u.wake();
            repeat (14)
            begin
               @(negedge clk);
               n += int'(resume_req === 1'b1);
               k += int'(flush_req === 1'b1);
            end
         join
         chk("resume pulses", 8'(c[1] & c[0]), 8'(n));
         chk("flush pulses", 8'(!c[1]), 8'(k));
      end
      @(posedge clk);
      power_enable_n <= 1'b0;
      ext_u.drive(8'h0A);
      bb_dir <= 8'hF0;
      for (c = 0; c < 2; c++)
      begin
         repeat (4) @(posedge clk);
         cfg_mode <= c ? afb_pkg::AFB_MODE_BB_SYN : afb_pkg::AFB_MODE_BB_ASYN;
         // empty the sample buffer, then let new samples stay to be read
         tx_ready <= 1'b1;
         repeat (16) @(posedge clk);
         tx_ready <= 1'b0;
         push(8'h5C, ok);
         rx_valid <= 1'b0;
         for (i = 0; i < 200; i++)
         begin
            @(negedge clk);
            if (out_update_strobe_n === 1'b0)
               break;
         end
         if (i == 200)
            to_fail("out_update_strobe_n");
         chk("bb oe", 8'hF0, port_a_data_oe);
         chk("bb out", 8'h50, port_a_data_out & 8'hF0);
         // sync mode samples with the update, so track both pulses at once
         for (k = 1; k < 20; k++)
         begin
            f = in_sample_strobe;
            @(negedge clk);
            if (out_update_strobe_n !== 1'b0)
               break;
         end
         chk("update width", 8'h05, 8'(k));
         for (i = 0; i < 200; i++)
         begin
            if (f === 1'b0 && in_sample_strobe === 1'b1)
               break;
            f = in_sample_strobe;
            @(negedge clk);
         end
         if (i == 200)
            to_fail("in_sample_strobe");
         chk("bb sample valid", 8'h01, 8'(tx_valid));
         chk("bb sample", 8'h0A, tx_data & 8'h0F);
         @(posedge clk);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
